/* src/caf_pkg.sv */
// Constants for the CAN acceptance filter control block.
// Assumes a 32-bit AXI4-Lite register bus.
package caf_pkg;
  localparam int          CAF_NUM_FILT       = 4;
  localparam int          CAF_FIRST_FILT     = 24;
  localparam logic [11:0] CAF_OFF_FILT_CTRL  = 12'h000;
  localparam logic [11:0] CAF_OFF_ID_BASE    = 12'h010;
  localparam logic [11:0] CAF_OFF_MASK_BASE  = 12'h020;
  localparam logic [11:0] CAF_OFF_RX_ID      = 12'h030;
  localparam logic [11:0] CAF_OFF_MATCH      = 12'h034;
  localparam logic [31:0] CAF_FILT_CTRL_RST  = 32'h0000_0000;
  localparam logic [28:0] CAF_ID_RST         = 29'h0000_0000;
  localparam int          CAF_EN_BIT         = 7;
  localparam int          CAF_MSEL_LSB       = 5;
  localparam int          CAF_DEST_LSB       = 0;
  localparam logic [1:0]  CAF_RESP_OKAY      = 2'h0;
  localparam logic [1:0]  CAF_RESP_SLVERR    = 2'h2;
endpackage : caf_pkg

/* src/caf_filter_ctrl.sv */
// CAN acceptance filter control for filters 24 to 27, with AXI4-Lite slave.
// Assumes a single clock aclk and synchronous active-low reset aresetn.
//
// What this block does
// - Each filter has an enable bit that puts it in or takes it out of acceptance.
// - Each filter has a two-bit code choosing which of the four acceptance masks applies.
// - Each filter has a five-bit destination naming the receive FIFO 0 to 31 for matches.
// - A filter's mask choice and destination can be changed only while its enable is zero.
// - One filter per byte, filter 27 on top, enable at bit 7, mask choice at 6:5, destination at 4:0.
`timescale 1ns/1ps
module caf_filter_ctrl
  import caf_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [3:0]       match_reg,
  output logic [4:0]       match_dest_fifo_reg,
  output logic             match_any_reg
);
  logic [31:0] can_filter_ctrl_24_27_reg;
  logic [28:0] filt_id_reg [CAF_NUM_FILT];
  logic [28:0] mask_reg [CAF_NUM_FILT];
  logic [28:0] rx_id_reg;
  logic [11:0] aw_addr_reg;
  logic        aw_have_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic        w_have_reg;
  logic        do_write;
  logic [31:0] rd_word;
  logic        rd_hit;
  logic        wr_hit;
  logic [3:0]  match_next;
  logic [4:0]  dest_next;
  logic        aw_have_next;
  logic        w_have_next;
  logic        bvalid_next;

  assign do_write      = aw_have_reg & w_have_reg & ~s_axi_bvalid;
  assign aw_have_next  = (s_axi_awvalid & s_axi_awready) | (aw_have_reg & ~do_write);
  assign w_have_next   = (s_axi_wvalid & s_axi_wready) | (w_have_reg & ~do_write);
  assign bvalid_next   = do_write | (s_axi_bvalid & ~s_axi_bready);

  // Write readies from flops, each the complement of the holding or response state that follows
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
    end
    else
    begin
      s_axi_awready <= ~aw_have_next & ~bvalid_next;
      s_axi_wready  <= ~w_have_next & ~bvalid_next;
    end
  end

  // Write address and data capture, in either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_reg <= 1'b0;
      w_have_reg  <= 1'b0;
      aw_addr_reg <= 12'h000;
      w_data_reg  <= 32'h0000_0000;
      w_strb_reg  <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      else if (do_write)
        aw_have_reg <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      else if (do_write)
        w_have_reg <= 1'b0;
    end
  end

  always_comb
  begin
    wr_hit = (aw_addr_reg[11:2] == CAF_OFF_FILT_CTRL[11:2]) || (aw_addr_reg[11:2] == CAF_OFF_RX_ID[11:2]);
    for (int i = 0; i < CAF_NUM_FILT; i++)
    begin
      if (aw_addr_reg[11:2] == CAF_OFF_ID_BASE[11:2] + 10'(i))
        wr_hit = 1'b1;
      if (aw_addr_reg[11:2] == CAF_OFF_MASK_BASE[11:2] + 10'(i))
        wr_hit = 1'b1;
    end
  end

  // Write response
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= CAF_RESP_OKAY;
    end
    else if (do_write)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? CAF_RESP_OKAY : CAF_RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // Filter control register, byte per filter
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      can_filter_ctrl_24_27_reg <= CAF_FILT_CTRL_RST;
    else if (do_write && aw_addr_reg[11:2] == CAF_OFF_FILT_CTRL[11:2])
    begin
      for (int i = 0; i < CAF_NUM_FILT; i++)
      begin
        if (w_strb_reg[i])
        begin
          can_filter_ctrl_24_27_reg[8*i+CAF_EN_BIT] <= w_data_reg[8*i+CAF_EN_BIT];
          if (!can_filter_ctrl_24_27_reg[8*i+CAF_EN_BIT])
            can_filter_ctrl_24_27_reg[8*i +: 7] <= w_data_reg[8*i +: 7];
        end
      end
    end
  end

  // Filter identifiers, acceptance masks and received identifier
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rx_id_reg <= CAF_ID_RST;
      for (int i = 0; i < CAF_NUM_FILT; i++)
      begin
        filt_id_reg[i] <= CAF_ID_RST;
        mask_reg[i]    <= CAF_ID_RST;
      end
    end
    else if (do_write && w_strb_reg == 4'hF)
    begin
      if (aw_addr_reg[11:2] == CAF_OFF_RX_ID[11:2])
        rx_id_reg <= w_data_reg[28:0];
      for (int i = 0; i < CAF_NUM_FILT; i++)
      begin
        if (aw_addr_reg[11:2] == CAF_OFF_ID_BASE[11:2] + 10'(i))
          filt_id_reg[i] <= w_data_reg[28:0];
        if (aw_addr_reg[11:2] == CAF_OFF_MASK_BASE[11:2] + 10'(i))
          mask_reg[i] <= w_data_reg[28:0];
      end
    end
  end

  // Match evaluation; lowest filter wins the destination
  always_comb
  begin
    match_next = 4'h0;
    dest_next  = 5'h00;
    for (int i = CAF_NUM_FILT - 1; i >= 0; i--)
    begin
      match_next[i] = can_filter_ctrl_24_27_reg[8*i+CAF_EN_BIT] &&
        (((rx_id_reg ^ filt_id_reg[i]) & mask_reg[can_filter_ctrl_24_27_reg[8*i+CAF_MSEL_LSB +: 2]]) == 29'h0);
      if (match_next[i])
        dest_next = can_filter_ctrl_24_27_reg[8*i+CAF_DEST_LSB +: 5];
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      match_reg           <= 4'h0;
      match_dest_fifo_reg <= 5'h00;
      match_any_reg       <= 1'b0;
    end
    else
    begin
      match_reg           <= match_next;
      match_dest_fifo_reg <= dest_next;
      match_any_reg       <= |match_next;
    end
  end

  // Read decode
  always_comb
  begin
    rd_word = 32'h0000_0000;
    rd_hit  = 1'b1;
    if (s_axi_araddr[11:2] == CAF_OFF_FILT_CTRL[11:2])
      rd_word = can_filter_ctrl_24_27_reg;
    else if (s_axi_araddr[11:2] == CAF_OFF_RX_ID[11:2])
      rd_word = {3'h0, rx_id_reg};
    else if (s_axi_araddr[11:2] == CAF_OFF_MATCH[11:2])
      rd_word = {19'h0, |match_reg, match_dest_fifo_reg, 3'h0, match_reg};
    else
    begin
      rd_hit = 1'b0;
      for (int i = 0; i < CAF_NUM_FILT; i++)
      begin
        if (s_axi_araddr[11:2] == CAF_OFF_ID_BASE[11:2] + 10'(i))
        begin
          rd_word = {3'h0, filt_id_reg[i]};
          rd_hit  = 1'b1;
        end
        if (s_axi_araddr[11:2] == CAF_OFF_MASK_BASE[11:2] + 10'(i))
        begin
          rd_word = {3'h0, mask_reg[i]};
          rd_hit  = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= CAF_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid  <= 1'b1;
      s_axi_arready <= 1'b0;
      s_axi_rdata   <= rd_word;
      s_axi_rresp   <= rd_hit ? CAF_RESP_OKAY : CAF_RESP_SLVERR;
    end
    else if (s_axi_rready)
    begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
endmodule : caf_filter_ctrl

/* sim/caf_filter_ctrl_assertions.sv */
// Port checker for the filter control block.
// Assumes one clock and a master that keeps bready high.
`timescale 1ns/1ps
module caf_filter_ctrl_assertions
(
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       s_axi_awvalid,
  input wire logic       s_axi_awready,
  input wire logic       s_axi_wvalid,
  input wire logic       s_axi_wready,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic       s_axi_rvalid,
  input wire logic [3:0] match_reg,
  input wire logic [4:0] match_dest_fifo_reg,
  input wire logic       match_any_reg
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  a_wr_answer: assert property (s_wr_take |-> ##2 s_axi_bvalid) else $error("bvalid late");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("rvalid late");
  a_any_or: assert property (match_any_reg == |match_reg) else $error("any wrong");
  a_dest_idle: assert property (!match_any_reg |-> match_dest_fifo_reg == 5'h00) else $error("dest wrong");
  a_rd_block: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("arready high");
  a_wr_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("awready high");
endmodule : caf_filter_ctrl_assertions
bind caf_filter_ctrl caf_filter_ctrl_assertions u_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .match_reg,
  .match_dest_fifo_reg, .match_any_reg);

/* sim/tb_caf_filter_ctrl.sv */
// Self-checking bench for the filter control block.
// Assumes AXI4-Lite answers; bready and rready stay high.
`timescale 1ns/1ps
module tb_caf_filter_ctrl
  import caf_pkg::*;
;
  logic        aclk = 1'h0, aresetn = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_arvalid = 1'h0;
  logic        s_axi_bready = 1'h1, s_axi_rready = 1'h1, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid, match_any_reg;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, ctrl_m, d, st, rx_m, id_m [4], mask_m [4];
  logic [3:0]  s_axi_wstrb = 4'h0, match_reg;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic [4:0]  match_dest_fifo_reg;
  int          n_errors = 0, check_count = 0, cyc = 0;
  int unsigned seed = 81579;
  caf_filter_ctrl u_caf_filter_ctrl (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .match_reg,
    .match_dest_fifo_reg, .match_any_reg);
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic conclude();
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : conclude
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp
  task automatic wr(input logic [11:0] a, input logic [31:0] v, input logic [3:0] s);
    logic ta, tw;
    ta = 1'h0;
    tw = 1'h0;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    do
    begin
      @(negedge aclk);
      ta |= s_axi_awready;
      tw |= s_axi_wready;
      @(posedge aclk);
      s_axi_awvalid <= !ta;
      s_axi_wvalid <= !tw;
    end
    while (!(ta && tw));
    do @(negedge aclk); while (!s_axi_bvalid);
    r = s_axi_bresp;
    @(posedge aclk);
  endtask : wr
  task automatic rd(input logic [11:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do @(negedge aclk); while (!s_axi_arready);
    @(posedge aclk);
    s_axi_arvalid <= 1'h0;
    do @(negedge aclk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    @(posedge aclk);
  endtask : rd
  initial
  begin
    forever #20 aclk = ~aclk;
  end
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_errors++;
      conclude();
    end
  end
  initial
  begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    ctrl_m = CAF_FILT_CTRL_RST;
    rd(CAF_OFF_FILT_CTRL);
    cmp(d, ctrl_m);
    for (int i = 0; i < 4; i++)
    begin
      id_m[i] = rnd() & 32'h1FFF_FFFF;
      mask_m[i] = rnd() & rnd() & 32'h1FFF_FFFF;
      wr(CAF_OFF_ID_BASE + 12'(4 * i), id_m[i], 4'hF);
      wr(CAF_OFF_MASK_BASE + 12'(4 * i), mask_m[i], 4'hF);
    end
    $display("setup test done");
    for (int n = 0; n < 40; n++)
    begin
      d = rnd();
      st = rnd();
      wr(CAF_OFF_FILT_CTRL, d, st[3:0]);
      for (int i = 0; i < 4; i++)
        if (st[i])
        begin
          if (!ctrl_m[8 * i + 7])
            ctrl_m[8 * i +: 7] = d[8 * i +: 7];
          ctrl_m[8 * i + 7] = d[8 * i + 7];
        end
      rx_m = id_m[st[5:4]] ^ (rnd() & rnd() & rnd() & 32'h1FFF_FFFF);
      wr(CAF_OFF_RX_ID, rx_m, 4'hF);
      cmp({30'h0, r}, {30'h0, CAF_RESP_OKAY});
      rd(CAF_OFF_FILT_CTRL);
      cmp(d, ctrl_m);
      st = 32'h0;
      for (int i = 3; i >= 0; i--)
        if (ctrl_m[8 * i + 7] && ((rx_m ^ id_m[i]) & mask_m[ctrl_m[8 * i + 5 +: 2]]) == 32'h0)
        begin
          st[i] = 1'h1;
          st[12] = 1'h1;
          st[11:7] = ctrl_m[8 * i +: 5];
        end
      rd(CAF_OFF_MATCH);
      cmp(d, st);
      cmp({30'h0, r}, {30'h0, CAF_RESP_OKAY});
      cmp({19'h0, match_any_reg, match_dest_fifo_reg, 3'h0, match_reg}, st);
    end
    $display("filter test done");
    aresetn <= 1'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    rd(CAF_OFF_FILT_CTRL);
    cmp(d, CAF_FILT_CTRL_RST);
    cmp({19'h0, match_any_reg, match_dest_fifo_reg, 3'h0, match_reg}, 32'h0);
    $display("reset test done");
    rd(12'h040);
    cmp({30'h0, r}, {30'h0, CAF_RESP_SLVERR});
    cmp(d, 32'h0);
    wr(CAF_OFF_MATCH, 32'hFFFF_FFFF, 4'hF);
    cmp({30'h0, r}, {30'h0, CAF_RESP_SLVERR});
    $display("unmapped test done");
    conclude();
  end
endmodule : tb_caf_filter_ctrl
